// ### src/mids_top.sv
// Motor input detection stage: noise filter, tacho and encoder input path
//
// The placing of the registers and the APB slave port were left to the implementer.
`default_nettype none
module mids_top
  import mids_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Phase inputs from sensors
  input wire logic phase_input_a,
  input wire logic phase_input_b,
  input wire logic phase_input_c,
  // Timing from the rest of the motor controller
  input wire logic pwm_state,
  input wire logic commutation_event,
  input wire logic sample_tick,
  // Comparator results for back-EMF detection
  input wire logic demag_cmp,
  input wire logic zc_cmp,
  // Filtered samples
  output logic demag_sample_valid,
  output logic demag_sample,
  output logic zc_sample_valid,
  output logic zc_sample,
  // Speed sensor events and pin usage
  output logic tacho_capture,
  output logic encoder_clk,
  output logic encoder_direction_flag,
  output logic speed_sensor_mode,
  output logic [2:0] release_io
);
  // ==========================================================
  // Register state
  logic [9:0] ctrl_reg;
  logic [1:0] active_is_reg;
  logic [15:0] count_reg;
  logic [31:0] prdata_reg;
  logic pwm_prev_reg;
  logic demag_valid_reg;
  logic demag_reg;
  logic zc_valid_reg;
  logic zc_reg;
  logic tacho_reg;
  logic enc_clk_reg;
  logic dir_reg;

  // ==========================================================
  // APB decode
  wire logic hit_ctrl = (paddr == MIDS_ADDR_CTRL);
  wire logic hit_status = (paddr == MIDS_ADDR_STATUS);
  wire logic hit_count = (paddr == MIDS_ADDR_COUNT);
  wire logic mapped = hit_ctrl | hit_status | hit_count;
  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic ctrl_wr = access_ph & pwrite & hit_ctrl;

  // Zero wait state: every transfer completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_reg;

  // ==========================================================
  // Control fields
  wire logic [1:0] tes = ctrl_reg[MIDS_CTRL_TES_LSB +: 2];
  wire logic [1:0] shadow_is = ctrl_reg[MIDS_CTRL_IS_LSB +: 2];
  wire logic hfs_en = ctrl_reg[MIDS_CTRL_HFS_BIT];
  wire logic [3:0] ds = ctrl_reg[MIDS_CTRL_DS_LSB +: 4];
  wire logic dac = ctrl_reg[MIDS_CTRL_DAC_BIT];
  wire logic [9:0] ctrl_wdata = pwdata[MIDS_CTRL_W-1:0];
  wire logic [1:0] wr_is = ctrl_wdata[MIDS_CTRL_IS_LSB +: 2];
  // Direct access counts if set before or within the same write
  wire logic dac_wr = ctrl_wr & (dac | ctrl_wdata[MIDS_CTRL_DAC_BIT]);

  // ==========================================================
  // Mode decode
  wire logic speed_mode = (tes != MIDS_TES_NONE);
  wire logic enc_mode = speed_mode & (active_is_reg == MIDS_IS_ENCODER);
  wire logic tacho_mode = speed_mode & ~enc_mode;
  wire mids_mode_e mode = enc_mode ? MIDS_MODE_ENCODER :
                          tacho_mode ? MIDS_MODE_TACHO : MIDS_MODE_POSITION;
  wire logic zc_hf_mode = hfs_en & (ds == MIDS_DS_NONE);

  // ==========================================================
  // Phase input synchronisers
  logic a_s;
  logic a_d;
  logic b_s;
  logic b_d;
  logic c_s;
  logic c_d;

  mids_sync u_sync_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(phase_input_a),
    .dout(a_s),
    .dout_prev(a_d)
  );
  mids_sync u_sync_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(phase_input_b),
    .dout(b_s),
    .dout_prev(b_d)
  );
  mids_sync u_sync_c (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(phase_input_c),
    .dout(c_s),
    .dout_prev(c_d)
  );

  // ==========================================================
  // Tacho path
  wire logic sel_now = (active_is_reg == 2'h0) ? a_s :
                       (active_is_reg == 2'h1) ? b_s : c_s;
  wire logic sel_prev = (active_is_reg == 2'h0) ? a_d :
                        (active_is_reg == 2'h1) ? b_d : c_d;
  wire logic sel_rise = sel_now & ~sel_prev;
  wire logic sel_fall = ~sel_now & sel_prev;
  wire logic tacho_hit = tacho_mode &
      (((tes == MIDS_TES_RISE) & sel_rise) |
       ((tes == MIDS_TES_FALL) & sel_fall) |
       ((tes == MIDS_TES_BOTH) & (sel_rise | sel_fall)));

  // ==========================================================
  // Encoder path
  // Any edge of either input clocks, so one missing input halves the rate
  wire logic a_edge = a_s ^ a_d;
  wire logic b_edge = b_s ^ b_d;
  wire logic b_fall = ~b_s & b_d;
  wire logic enc_hit = enc_mode & (a_edge | b_edge);

  // ==========================================================
  // Noise mask
  logic mask_active;
  wire logic pwm_edge = pwm_state ^ pwm_prev_reg;

  mids_mask_timer u_mask (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(pwm_edge),
    .mask_active(mask_active)
  );

  // ==========================================================
  // Pin release
  always_comb begin
    case (mode)
      MIDS_MODE_TACHO: release_io = ~(3'h1 << active_is_reg);
      MIDS_MODE_ENCODER: release_io = 3'h4;
      MIDS_MODE_POSITION: release_io = 3'h0;
      default: release_io = 3'h0;
    endcase
  end

  // ==========================================================
  // Read mux, loaded in the setup phase so data are stable in access
  wire logic [31:0] status_word = {26'h0, mask_active, active_is_reg, enc_mode, speed_mode,
                                   dir_reg};
  wire logic [31:0] rd_mux = hit_ctrl ? {22'h0, ctrl_reg} :
                             hit_status ? status_word :
                             hit_count ? {16'h0, count_reg} : 32'h0;

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= MIDS_CTRL_RESET;
      prdata_reg <= 32'h0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ctrl_wdata;
      end
      if (setup_ph) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Direct write wins over a simultaneous commutation load
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      active_is_reg <= 2'h0;
    end else if (dac_wr) begin
      active_is_reg <= wr_is;
    end else if (commutation_event) begin
      active_is_reg <= shadow_is;
    end
  end

  // Counter always counts up; direction is report-only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= MIDS_COUNT_RESET;
    end else if (tacho_reg | enc_clk_reg) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwm_prev_reg <= 1'b0;
      demag_valid_reg <= 1'b0;
      demag_reg <= 1'b0;
      zc_valid_reg <= 1'b0;
      zc_reg <= 1'b0;
    end else begin
      pwm_prev_reg <= pwm_state;
      demag_valid_reg <= sample_tick & ~mask_active;
      zc_valid_reg <= sample_tick & zc_hf_mode & ~mask_active;
      if (sample_tick) begin
        demag_reg <= demag_cmp;
        zc_reg <= zc_cmp;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tacho_reg <= 1'b0;
      enc_clk_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      tacho_reg <= tacho_hit;
      enc_clk_reg <= enc_hit;
      if (enc_mode & b_fall) begin
        dir_reg <= a_s;
      end
    end
  end

  assign demag_sample_valid = demag_valid_reg;
  assign demag_sample = demag_reg;
  assign zc_sample_valid = zc_valid_reg;
  assign zc_sample = zc_reg;
  assign tacho_capture = tacho_reg;
  assign encoder_clk = enc_clk_reg;
  assign encoder_direction_flag = dir_reg;
  assign speed_sensor_mode = speed_mode;

  // ==========================================================
  // Assertions
  demag_sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sample_tick && !mask_active) |=> (demag_sample_valid && demag_sample == $past(demag_cmp)))
    else $error("demag sample lost or wrong outside the noise mask");
  demag_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pwm_edge |=> !demag_sample_valid)
    else $error("demag sample passed right after a PWM edge");
  zc_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (zc_hf_mode && sample_tick) |=> (zc_sample_valid == !$past(mask_active)))
    else $error("zero-cross sample not gated by the noise mask");
  zc_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !zc_hf_mode |=> !zc_sample_valid)
    else $error("zero-cross sample produced outside high-rate mode");
  speed_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    speed_sensor_mode == (tes != MIDS_TES_NONE))
    else $error("speed sensor mode does not match edge select");
  tacho_rise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tacho_mode && tes == MIDS_TES_RISE) |-> ##1 (tacho_capture == $past(sel_rise)))
    else $error("rising tacho capture wrong");
  enc_clk_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (enc_mode && (a_edge || b_edge)) |=> encoder_clk)
    else $error("encoder edge gave no clock pulse");
  enc_dir_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (enc_mode && b_fall) |=> (encoder_direction_flag == $past(a_s)))
    else $error("direction flag not taken from A at B falling edge");
  preload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (commutation_event && !dac_wr) |=> (active_is_reg == $past(shadow_is)))
    else $error("input select not applied at commutation");
  tacho_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tacho_mode |-> ($countones(release_io) == 2 && !release_io[active_is_reg]))
    else $error("tacho mode pin release wrong");
endmodule // mids_top
`default_nettype wire

// ### src/mids_pkg.sv
// Shared constants and types of the motor input detection stage
`default_nettype none
package mids_pkg;
  // ==========================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] MIDS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] MIDS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] MIDS_ADDR_COUNT = 8'h08;
  // ==========================================================
  // Control register fields
  localparam int MIDS_CTRL_TES_LSB = 0;
  localparam int MIDS_CTRL_IS_LSB = 2;
  localparam int MIDS_CTRL_HFS_BIT = 4;
  localparam int MIDS_CTRL_DS_LSB = 5;
  localparam int MIDS_CTRL_DAC_BIT = 9;
  localparam int MIDS_CTRL_W = 10;
  localparam logic [9:0] MIDS_CTRL_RESET = 10'h000;
  // ==========================================================
  // Status and count register fields
  localparam int MIDS_STAT_DIR_BIT = 0;
  localparam int MIDS_STAT_SPEED_BIT = 1;
  localparam int MIDS_STAT_ENC_BIT = 2;
  localparam int MIDS_STAT_IS_LSB = 3;
  localparam int MIDS_STAT_MASK_BIT = 5;
  localparam int MIDS_COUNT_W = 16;
  localparam logic [15:0] MIDS_COUNT_RESET = 16'h0000;
  // ==========================================================
  // Field encodings
  localparam logic [1:0] MIDS_TES_NONE = 2'h0;
  localparam logic [1:0] MIDS_TES_RISE = 2'h1;
  localparam logic [1:0] MIDS_TES_FALL = 2'h2;
  localparam logic [1:0] MIDS_TES_BOTH = 2'h3;
  localparam logic [1:0] MIDS_IS_ENCODER = 2'h3;
  localparam logic [3:0] MIDS_DS_NONE = 4'h0;
  // ==========================================================
  // Timing
  localparam int MIDS_CLK_PERIOD_NS = 10;
  localparam int MIDS_NOISE_MASK_NS = 1000;
  localparam int MIDS_NOISE_MASK_CYCLES =
      (MIDS_NOISE_MASK_NS + MIDS_CLK_PERIOD_NS - 1) / MIDS_CLK_PERIOD_NS;
  localparam int MIDS_MASK_CNT_W = 7;
  localparam logic [6:0] MIDS_MASK_LOAD = 7'(MIDS_NOISE_MASK_CYCLES - 1);
  // ==========================================================
  // Input stage modes
  typedef enum logic [1:0] {
    MIDS_MODE_POSITION = 2'b00,
    MIDS_MODE_TACHO = 2'b01,
    MIDS_MODE_ENCODER = 2'b10
  } mids_mode_e;
endpackage
`default_nettype wire

// ### src/mids_sync.sv
// Two-flop synchroniser with one delayed copy for edge detection
`default_nettype none
module mids_sync
  import mids_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Data
  input wire logic din,
  output logic dout,
  output logic dout_prev
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign dout = sync_reg;
  assign dout_prev = prev_reg;

  sync_path_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##2 (dout == $past(din, 2)))
    else $error("synchroniser output does not follow input after two edges");
endmodule // mids_sync
`default_nettype wire

// ### src/mids_mask_timer.sv
// Commutation noise mask timer, restarted by every PWM edge
`default_nettype none
module mids_mask_timer
  import mids_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic restart,
  output logic mask_active
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;

  // The edge cycle itself is masked, so the counter holds the remaining cycles
  assign cnt_next = restart ? MIDS_MASK_LOAD :
                    (cnt_reg != 7'h00) ? cnt_reg - 7'h01 : 7'h00;
  assign mask_active = restart | (cnt_reg != 7'h00);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  mask_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    restart |-> mask_active [*8])
    else $error("noise mask released too early after a PWM edge");
  mask_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cnt_reg == 7'h01 && !restart) |=> (restart || !mask_active))
    else $error("noise mask does not end after its full length");
endmodule // mids_mask_timer
`default_nettype wire

// ### test/mids_sensor_model.sv
// Sensor model: tacho pulses or quadrature encoder waves on the phase inputs
`default_nettype none
module mids_sensor_model (
  // Clock and command
  input wire logic clk_sys,
  input wire logic start,
  input wire logic quad,
  input wire logic reverse,
  input wire logic one_only,
  input wire logic [1:0] sel,
  input wire logic [7:0] steps,
  // Sensor side
  output logic phase_a,
  output logic phase_b,
  output logic phase_c,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg = 8'h00;
  logic [2:0] gap_reg = 3'h0;
  logic [1:0] q_reg = 2'h0;
  logic [2:0] pins_reg = 3'h0;
  logic [2:0] flip;
  assign busy = (left_reg != 8'h00);
  // Free pins toggle twice as often as the selected one, so a wrong mux shows
  assign flip = quad ? 3'h4 : (left_reg[0] ? 3'h7 : ~(3'h1 << sel));
  // A leads B going forward; an unconnected B is held low
  assign phase_a = quad ? (q_reg[1] ^ q_reg[0]) : pins_reg[0];
  assign phase_b = quad ? (q_reg[1] & ~one_only) : pins_reg[1];
  assign phase_c = pins_reg[2];
  always @(posedge clk_sys) begin
    gap_reg <= gap_reg + 3'h1;
    if (start) begin
      left_reg <= steps;
      gap_reg <= 3'h0;
    end else if (busy && gap_reg == 3'h3) begin
      left_reg <= left_reg - 8'h01;
      pins_reg <= pins_reg ^ flip;
      if (quad) begin
        q_reg <= reverse ? q_reg - 2'h1 : q_reg + 2'h1;
      end
    end
  end
endmodule // mids_sensor_model
`default_nettype wire

// ### test/mids_top_test.sv
// Self-checking bench for the motor input detection stage
`default_nettype none
module mids_top_test
  import mids_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, phase_a, phase_b, phase_c, m_busy;
  logic pwm_state = 1'b0, commutation_event = 1'b0, sample_tick = 1'b0;
  logic demag_cmp = 1'b0, zc_cmp = 1'b0;
  logic demag_sample_valid, demag_sample, zc_sample_valid, zc_sample;
  logic tacho_capture, encoder_clk, encoder_direction_flag, speed_sensor_mode;
  logic [2:0] release_io;
  logic m_start = 1'b0, m_quad = 1'b0, m_rev = 1'b0, m_one = 1'b0;
  logic [1:0] m_sel = 2'h0;
  logic [7:0] m_steps = 8'h08;
  int num_errors = 0, checked = 0, n_dv = 0, n_zv = 0, n_tc = 0, n_ec = 0;
  logic [31:0] q;
  logic e;

  always #5 clk_sys = ~clk_sys;

  mids_top mids_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_input_a(phase_a),
    .phase_input_b(phase_b), .phase_input_c(phase_c), .pwm_state(pwm_state),
    .commutation_event(commutation_event), .sample_tick(sample_tick),
    .demag_cmp(demag_cmp), .zc_cmp(zc_cmp), .demag_sample_valid(demag_sample_valid),
    .demag_sample(demag_sample), .zc_sample_valid(zc_sample_valid),
    .zc_sample(zc_sample), .tacho_capture(tacho_capture), .encoder_clk(encoder_clk),
    .encoder_direction_flag(encoder_direction_flag),
    .speed_sensor_mode(speed_sensor_mode), .release_io(release_io));

  mids_sensor_model mids_sensor_model_inst (.clk_sys(clk_sys), .start(m_start),
    .quad(m_quad), .reverse(m_rev), .one_only(m_one), .sel(m_sel), .steps(m_steps),
    .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c), .busy(m_busy));

  always @(posedge clk_sys) begin
    if (demag_sample_valid === 1'b1) n_dv++;
    if (zc_sample_valid === 1'b1) n_zv++;
    if (tacho_capture === 1'b1) n_tc++;
    if (encoder_clk === 1'b1) n_ec++;
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends at the falling edge so that register effects have settled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  function automatic logic [31:0] ctrl(logic [1:0] tes, logic [1:0] is, logic hfs,
                                       logic [3:0] ds, logic dac);
    return 32'({dac, ds, hfs, is, tes});
  endfunction

  task automatic sensor(input logic quad, input logic rev, input logic one,
                        input logic [1:0] sel);
    int n;
    n = 0;
    @(posedge clk_sys);
    m_quad <= quad;
    m_rev <= rev;
    m_one <= one;
    m_sel <= sel;
    m_start <= 1'b1;
    @(posedge clk_sys);
    m_start <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (m_busy && n < 100);
    if (n >= 100) begin
      num_errors++;
      summarize();
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk("ctrl reset", MIDS_ADDR_CTRL, 32'h0);
    apb(1'b1, MIDS_ADDR_STATUS, 32'hFFFFFFFF);
    rd_chk("status read-only", MIDS_ADDR_STATUS, 32'h0);
    rd_chk("count reset", MIDS_ADDR_COUNT, 32'h0);
    check("mapped no error", e, 1'b0);
    rd_chk("unmapped data", 8'h0C, 32'h0);
    check("unmapped error", e, 1'b1);
    check("position mode", speed_sensor_mode, 1'b0);
    check("no free pins", release_io, 3'h0);
    $display("test reset done");
    // Ticks 50 cycles apart stand for 2 MHz sampling: only the tick 100 cycles after the edge passes
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, MIDS_ADDR_CTRL, ctrl(2'h0, 2'h0, k != 1, (k == 2) ? 4'h3 : 4'h0, 1'b0));
      n_dv = 0;
      n_zv = 0;
      for (int i = 0; i <= 100; i++) begin
        @(posedge clk_sys);
        if (i == 0) pwm_state <= ~pwm_state;
        if (i == 0) demag_cmp <= (k != 1);
        if (i == 0) zc_cmp <= (k == 1);
        sample_tick <= (i == 0 || i == 50 || i == 100);
      end
      @(posedge clk_sys);
      sample_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("demag valid count", n_dv, 1);
      check("zc valid count", n_zv, 32'(k == 0));
      check("demag value", demag_sample, 32'(k != 1));
      check("zc value", zc_sample, 32'(k == 1));
    end
    $display("test noise mask done");
    for (int t = 1; t < 4; t++) begin
      for (int s = 0; s < 3; s++) begin
        apb(1'b1, MIDS_ADDR_CTRL, ctrl(2'(t), 2'(s), 1'b0, 4'h0, 1'b1));
        check("speed mode", speed_sensor_mode, 1'b1);
        check("free pins", release_io, 3'h7 & ~(3'h1 << s));
        n_tc = 0;
        n_ec = 0;
        sensor(1'b0, 1'b0, 1'b0, 2'(s));
        check("tacho captures", n_tc, (t == 3) ? 4 : 2);
        check("no encoder clock", n_ec, 0);
      end
    end
    $display("test tacho done");
    apb(1'b1, MIDS_ADDR_CTRL, ctrl(2'h1, 2'h0, 1'b0, 4'h0, 1'b0));
    apb(1'b1, MIDS_ADDR_CTRL, ctrl(2'h1, 2'h2, 1'b0, 4'h0, 1'b0));
    rd_chk("select held", MIDS_ADDR_STATUS, 32'h2);
    @(posedge clk_sys);
    commutation_event <= 1'b1;
    @(posedge clk_sys);
    commutation_event <= 1'b0;
    rd_chk("select loaded", MIDS_ADDR_STATUS, 32'h12);
    check("free pins loaded", release_io, 3'h3);
    $display("test preload done");
    apb(1'b1, MIDS_ADDR_CTRL, ctrl(2'h2, 2'h3, 1'b0, 4'h0, 1'b1));
    check("encoder free pins", release_io, 3'h4);
    n_tc = 0;
    n_ec = 0;
    sensor(1'b1, 1'b0, 1'b0, 2'h0);
    check("encoder clock fwd", n_ec, 8);
    check("direction fwd", encoder_direction_flag, 1'b0);
    sensor(1'b1, 1'b1, 1'b0, 2'h0);
    check("encoder clock rev", n_ec, 16);
    check("direction rev", encoder_direction_flag, 1'b1);
    sensor(1'b1, 1'b0, 1'b1, 2'h0);
    check("single input clock", n_ec, 20);
    check("no tacho in encoder", n_tc, 0);
    rd_chk("count upward", MIDS_ADDR_COUNT, 32'h2C);
    $display("test encoder done");
    summarize();
  end
endmodule // mids_top_test
`default_nettype wire
